// file: pkg/adc_regs_defines.svh
/*
 * constants of the converter register block: offsets, fields, reset values.
 * assumes inclusion by its bare name from the package and the core file.
 */
// What this block does
// [R1] 12-bit result held in a high and a low byte register, readable
// [R2] format 0: high holds bits 11..4, low upper nibble bits 3..0, rest zero
// [R3] format 1: high lower nibble bits 11..8, upper zero, low holds 7..0
// [R4] unused result bit positions always read zero
// [R5] with converter disabled the result registers stay unchanged
// [R6] one input at a time; 4-bit field picks the external channel
// [R7] 3-bit source field picks internal signal or external channel
// [R8] pin taken as analog input loses its I/O and shared functions
// [R9] pin taken as analog input has its pull-high removed
// [R10] two 8-bit control registers hold selection, format, start, busy
// [R11] busy bit read-only, shows conversion in progress; others read/write
// [R12] start bit written high then low begins a conversion
// [R13] busy set by start sequence or trigger falling edge, cleared at end
// [R14] enable bit powers the converter; cleared switches it off
// [R15] channel codes 0..13 select channels 0..13; 14 and 15 undefined
// [R16] both result bytes update together at conversion end
// [R17] writes to the busy bit are ignored
`ifndef ADC_REGS_DEFINES_SVH
`define ADC_REGS_DEFINES_SVH

`define ADDR_RESULT_LOW   8'h00
`define ADDR_RESULT_HIGH  8'h04
`define ADDR_CTRL_PRIMARY 8'h08
`define ADDR_CTRL_SECOND  8'h0C
`define ADDR_IRQ_STATUS   8'h10
`define ADDR_IRQ_CLEAR    8'h14
`define ADDR_IRQ_ENABLE   8'h18
`define ADDR_WIDTH        8

`define BIT_START         7
`define BIT_BUSY          6
`define BIT_ENABLE        5
`define BIT_JUSTIFY       4
`define FLD_CHAN_HI       3
`define FLD_SRC_HI        7
`define FLD_SRC_LO        5

`define CTRL_PRIMARY_RST  8'h00
`define CTRL_SECOND_RST   3'h0
`define SRC_EXTERNAL      3'h0
`define CHAN_LAST         4'hD
`define NUM_CHANNELS      14
`define RESULT_WIDTH      12
`define NUM_EVENTS        2
`define EVT_DONE          0
`define EVT_OVERRUN       1

`endif

// file: pkg/adc_regs_pkg.sv
/*
 * types of the converter register block: state struct and its enum.
 * assumes adc_regs_defines.svh is on the include path.
 */
`include "adc_regs_defines.svh"

package adc_regs_pkg;

    typedef enum logic {
        CONV_IDLE,
        CONV_BUSY
    } conv_state_e;

    typedef struct packed {
        conv_state_e                  conv;
        logic                         start_bit;
        logic                         enable;
        logic                         justify;
        logic [`FLD_CHAN_HI:0]        chan;
        logic [2:0]                   source;
        logic [`RESULT_WIDTH-1:0]     result;
        logic [`NUM_EVENTS-1:0]       irq_status;
        logic [`NUM_EVENTS-1:0]       irq_enable;
        logic                         trig_prev;
        logic                         ph_valid;
        logic                         ph_write;
        logic [`ADDR_WIDTH-1:0]       ph_addr;
        logic [31:0]                  hrdata;
        logic                         irq;
        logic                         conv_start;
        logic                         route_external;
        logic [`NUM_CHANNELS-1:0]     pin_disconnect;
        logic [`NUM_CHANNELS-1:0]     pin_pullup_off;
    } regs_state_s;

endpackage

// file: core/adc_result_and_control_regs.sv
/*
 * register block of a 12-bit converter: result pair, two control
 * registers, interrupt status/clear/enable, on an AHB-Lite slave.
 * assumes the analog circuit answers conv_start with one conv_done
 * pulse carrying conv_data, and a pin mux that reports analog pins.
 */
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "adc_regs_defines.svh"

module adc_result_and_control_regs (
    // clock and reset
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    // ahb-lite slave
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic [31:0]                   hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    // interrupt
    output logic                          irq,
    // analog converter side
    input  wire logic                     internal_conversion_trigger,
    input  wire logic                     conv_done,
    input  wire logic [`RESULT_WIDTH-1:0] conv_data,
    output logic                          conv_start,
    output logic                          converter_power_enable,
    output logic [3:0]                    external_channel_select,
    output logic [2:0]                    input_source_select,
    output logic                          route_external,
    // pin sharing
    input  wire logic [`NUM_CHANNELS-1:0] pin_analog_select,
    output logic [`NUM_CHANNELS-1:0]      pin_io_disconnect,
    output logic [`NUM_CHANNELS-1:0]      pin_pullup_disable
);

    adc_regs_pkg::regs_state_s q;
    adc_regs_pkg::regs_state_s d;

    logic                      addr_sel;
    logic                      wr_now;
    logic                      start_seq;
    logic                      trig_fall;
    logic                      want_start;
    logic [`NUM_EVENTS-1:0]    evt_set;
    logic [`NUM_EVENTS-1:0]    evt_clr;
    logic [7:0]                rd_byte;
    logic [7:0]                wbyte;

    // reset image of the primary control byte, split per field below
    localparam logic [7:0]     ctrl_rst_value = `CTRL_PRIMARY_RST;

    always_comb begin
        d          = q;
        evt_set    = '0;
        evt_clr    = '0;
        rd_byte    = 8'h00;
        wbyte      = hwdata[7:0];
        start_seq  = 1'b0;
        addr_sel   = hsel & htrans[1] & hready;
        wr_now     = q.ph_valid & q.ph_write;
        trig_fall  = q.trig_prev & ~internal_conversion_trigger;
        d.trig_prev = internal_conversion_trigger;

        // data phase write, taken from the captured address phase
        if (wr_now) begin
            if (q.ph_addr == `ADDR_CTRL_PRIMARY) begin
                // [R12] start falls after high
                start_seq    = q.start_bit & ~wbyte[`BIT_START];
                d.start_bit  = wbyte[`BIT_START];
                // [R17] busy bit ignored
                d.enable     = wbyte[`BIT_ENABLE];
                d.justify    = wbyte[`BIT_JUSTIFY];
                d.chan       = wbyte[`FLD_CHAN_HI:0];
            end else if (q.ph_addr == `ADDR_CTRL_SECOND) begin
                // [R7] source field stored
                d.source     = wbyte[`FLD_SRC_HI:`FLD_SRC_LO];
            end else if (q.ph_addr == `ADDR_IRQ_CLEAR) begin
                evt_clr      = hwdata[`NUM_EVENTS-1:0];
            end else if (q.ph_addr == `ADDR_IRQ_ENABLE) begin
                d.irq_enable = hwdata[`NUM_EVENTS-1:0];
            end
        end

        // conversion sequencing
        want_start   = start_seq | trig_fall;
        d.conv_start = 1'b0;
        case (q.conv)
            adc_regs_pkg::CONV_IDLE: begin
                // [R13] busy set on start
                // a write that powers down in the same cycle cancels it
                if (want_start && q.enable && d.enable) begin
                    d.conv       = adc_regs_pkg::CONV_BUSY;
                    d.conv_start = 1'b1;
                end
            end
            adc_regs_pkg::CONV_BUSY: begin
                if (!q.enable) begin
                    // [R14] power off aborts
                    d.conv = adc_regs_pkg::CONV_IDLE;
                end else if (conv_done) begin
                    // [R16] whole word at once
                    d.result           = conv_data;
                    d.conv             = adc_regs_pkg::CONV_IDLE;
                    evt_set[`EVT_DONE] = 1'b1;
                end
                // a restart while busy is dropped and reported
                if (want_start) begin
                    evt_set[`EVT_OVERRUN] = 1'b1;
                end
            end
            default: begin
                d.conv = adc_regs_pkg::CONV_IDLE;
            end
        endcase
        // [R5] result untouched when off
        if (!q.enable) begin
            d.result = q.result;
        end

        // sticky status: a set in the clear cycle wins
        d.irq_status = (q.irq_status & ~evt_clr) | evt_set;
        d.irq        = |(d.irq_status & d.irq_enable);

        // address phase: capture, and read from next state so a
        // write just before a read of the same register is seen
        d.ph_valid = addr_sel;
        d.ph_write = hwrite;
        d.ph_addr  = haddr[`ADDR_WIDTH-1:0];
        if (addr_sel && !hwrite) begin
            if (haddr[`ADDR_WIDTH-1:0] == `ADDR_RESULT_LOW) begin
                // [R1] [R2] [R4] low byte layout
                if (d.justify) begin
                    rd_byte = d.result[7:0];
                end else begin
                    rd_byte = {d.result[3:0], 4'h0};
                end
            end else if (haddr[`ADDR_WIDTH-1:0] == `ADDR_RESULT_HIGH) begin
                // [R3] [R4] high byte layout
                if (d.justify) begin
                    rd_byte = {4'h0, d.result[11:8]};
                end else begin
                    rd_byte = d.result[11:4];
                end
            end else if (haddr[`ADDR_WIDTH-1:0] == `ADDR_CTRL_PRIMARY) begin
                // [R10] [R11] busy shown live
                rd_byte = {d.start_bit, d.conv == adc_regs_pkg::CONV_BUSY,
                           d.enable, d.justify, d.chan};
            end else if (haddr[`ADDR_WIDTH-1:0] == `ADDR_CTRL_SECOND) begin
                rd_byte = {d.source, 5'h00};
            end else if (haddr[`ADDR_WIDTH-1:0] == `ADDR_IRQ_STATUS) begin
                rd_byte = {6'h00, d.irq_status};
            end else if (haddr[`ADDR_WIDTH-1:0] == `ADDR_IRQ_ENABLE) begin
                rd_byte = {6'h00, d.irq_enable};
            end
        end
        d.hrdata = {24'h000000, rd_byte};

        // [R6] [R15] one route, codes above 13 route nothing
        d.route_external = d.enable && (d.source == `SRC_EXTERNAL)
                           && (d.chan <= `CHAN_LAST);
        // [R8] [R9] analog pins lose io and pull-high
        d.pin_disconnect = pin_analog_select;
        d.pin_pullup_off = pin_analog_select;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q            <= '0;
            q.conv       <= adc_regs_pkg::CONV_IDLE;
            q.start_bit  <= ctrl_rst_value[`BIT_START];
            q.enable     <= ctrl_rst_value[`BIT_ENABLE];
            q.justify    <= ctrl_rst_value[`BIT_JUSTIFY];
            q.chan       <= ctrl_rst_value[`FLD_CHAN_HI:0];
            q.source     <= `CTRL_SECOND_RST;
        end else begin
            q <= d;
        end
    end

    // every output straight from the state flops, except hreadyout and hresp, which are tied constant
    assign hrdata                  = q.hrdata;
    assign hreadyout               = 1'b1;
    assign hresp                   = 1'b0;
    assign irq                     = q.irq;
    assign conv_start              = q.conv_start;
    assign converter_power_enable  = q.enable;
    assign external_channel_select = q.chan;
    assign input_source_select     = q.source;
    assign route_external          = q.route_external;
    assign pin_io_disconnect       = q.pin_disconnect;
    assign pin_pullup_disable      = q.pin_pullup_off;

endmodule

// file: verification/adc_regs_props.sv
/*
 * port checks of the converter register block.
 * assumes binding onto the core, hclk rising, hresetn active low.
 */
`timescale 1ns/1ps
`include "adc_regs_defines.svh"
module adc_regs_props (
    // clock and reset
    input wire logic                     hclk,
    input wire logic                     hresetn,
    // bus and converter
    input wire logic [31:0]              hrdata,
    input wire logic                     hreadyout,
    input wire logic                     hresp,
    input wire logic                     internal_conversion_trigger,
    input wire logic                     conv_done,
    input wire logic                     conv_start,
    input wire logic                     converter_power_enable,
    input wire logic [3:0]               external_channel_select,
    input wire logic [2:0]               input_source_select,
    input wire logic                     route_external,
    // pin sharing
    input wire logic [`NUM_CHANNELS-1:0] pin_analog_select,
    input wire logic [`NUM_CHANNELS-1:0] pin_io_disconnect,
    input wire logic [`NUM_CHANNELS-1:0] pin_pullup_disable
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic busy_q;
    // rises one edge after the core's busy and falls on the same edge, hence the conv_start guard below
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (busy_q || conv_start) && !conv_done && converter_power_enable;
        end
    end
    sequence trig_fall;
        $fell(internal_conversion_trigger) ##0 converter_power_enable ##0 (!busy_q && !conv_start);
    endsequence
    chk_trig_starts: assert property (trig_fall ##1 converter_power_enable |-> conv_start)
        else $error("no start on trigger");
    chk_start_pulse: assert property (conv_start |=> !conv_start) else $error("start too long");
    chk_start_enabled: assert property (conv_start |-> converter_power_enable) else $error("start while off");
    chk_route_one: assert property (route_external == (converter_power_enable && input_source_select == 3'h0
        && external_channel_select <= 4'hD)) else $error("route wrong");
    chk_pin_release: assert property ($past(hresetn) |-> pin_io_disconnect == $past(pin_analog_select))
        else $error("pin not released");
    chk_pullup_off: assert property ($past(hresetn) |-> pin_pullup_disable == $past(pin_analog_select))
        else $error("pull-high kept");
    chk_byte_regs: assert property (hrdata[31:8] == 24'h0) else $error("read above byte");
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
endmodule
bind adc_result_and_control_regs adc_regs_props adc_regs_props_inst (.hclk(hclk), .hresetn(hresetn),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .internal_conversion_trigger(internal_conversion_trigger),
    .conv_done(conv_done), .conv_start(conv_start), .converter_power_enable(converter_power_enable),
    .external_channel_select(external_channel_select), .input_source_select(input_source_select),
    .route_external(route_external), .pin_analog_select(pin_analog_select),
    .pin_io_disconnect(pin_io_disconnect), .pin_pullup_disable(pin_pullup_disable));

// file: verification/adc_result_and_control_regs_tb_top.sv
/*
 * bench of the converter register block over ahb-lite.
 * assumes the checker file is compiled too and binds itself.
 */
`timescale 1ns/1ps
`include "adc_regs_defines.svh"
module adc_result_and_control_regs_tb_top;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, trig = 1'b0, done = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic [11:0] cdata = 12'h0;
    logic [13:0] pins = 14'h0, disc, pull;
    logic        hready, hresp, irq, cstart, pwr, route;
    logic [3:0]  chan;
    logic [2:0]  src;
    int          errors = 0, checked = 0, cycles = 0;
    integer      seed = 99723;
    wire         hready_o;
    assign hready = hready_o;
    adc_result_and_control_regs adc_result_and_control_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready_o), .hresp(hresp), .irq(irq), .internal_conversion_trigger(trig),
        .conv_done(done), .conv_data(cdata), .conv_start(cstart), .converter_power_enable(pwr),
        .external_channel_select(chan), .input_source_select(src), .route_external(route),
        .pin_analog_select(pins), .pin_io_disconnect(disc), .pin_pullup_disable(pull));
    always #12.5 hclk = ~hclk;
    task automatic report_and_stop();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, real run is a few hundred cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        pins <= 14'($random(seed));
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(a, 1'b0, 32'h0, d);
        check(d, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [31:0] d;
        bus(a, 1'b1, {24'h0, v}, d);
    endtask
    task automatic pulse_trig();
        trig <= 1'b1;
        @(posedge hclk);
        trig <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    task automatic finish_conv(input logic [11:0] d);
        done <= 1'b1;
        cdata <= d;
        @(posedge hclk);
        done <= 1'b0;
        cdata <= ~d;
        @(posedge hclk);
    endtask
    function automatic logic [31:0] exp_hi(input logic [11:0] d, input logic j);
        return j ? {28'h0, d[11:8]} : {24'h0, d[11:4]};
    endfunction
    function automatic logic [31:0] exp_lo(input logic [11:0] d, input logic j);
        return j ? {24'h0, d[7:0]} : {24'h0, d[3:0], 4'h0};
    endfunction
    initial begin
        logic [11:0] d;
        logic [7:0]  v;
        logic [2:0]  s;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`ADDR_CTRL_PRIMARY, 32'h0); // reset value
        wr(`ADDR_CTRL_PRIMARY, 8'h40);
        rd(`ADDR_CTRL_PRIMARY, 32'h0); // busy not writable
        rd(8'h1C, 32'h0);
        wr(`ADDR_IRQ_ENABLE, 8'h03);
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 12'hFFF : 12'($random(seed));
            v = {3'b001, i[0], 4'($random(seed))};
            s = 3'($random(seed));
            wr(`ADDR_CTRL_SECOND, {s, 5'h1F});
            rd(`ADDR_CTRL_SECOND, {24'h0, s, 5'h00}); // source field, rest zero
            check({29'h0, src}, {29'h0, s});
            if (i[1]) begin
                wr(`ADDR_CTRL_PRIMARY, v | 8'h80);
                wr(`ADDR_CTRL_PRIMARY, v);
            end else begin
                wr(`ADDR_CTRL_PRIMARY, v);
                pulse_trig();
            end
            rd(`ADDR_CTRL_PRIMARY, {24'h0, v | 8'h40});
            check({28'h0, chan}, {28'h0, v[3:0]});
            // second start while busy only flags overrun
            if (i == 3) pulse_trig();
            finish_conv(d);
            rd(`ADDR_CTRL_PRIMARY, {24'h0, v}); // busy cleared
            rd(`ADDR_RESULT_HIGH, exp_hi(d, i[0]));
            rd(`ADDR_RESULT_LOW, exp_lo(d, i[0]));
            rd(`ADDR_IRQ_STATUS, {30'h0, i == 3, 1'b1});
            check({31'h0, irq}, 32'h1);
            wr(`ADDR_IRQ_CLEAR, 8'h03);
            repeat (2) @(posedge hclk);
            check({31'h0, irq}, 32'h0);
        end
        wr(`ADDR_CTRL_PRIMARY, 8'hA0);
        wr(`ADDR_CTRL_PRIMARY, 8'h20);
        wr(`ADDR_CTRL_PRIMARY, 8'h00);
        finish_conv(~d);
        rd(`ADDR_RESULT_HIGH, exp_hi(d, 1'b0)); // kept while off
        rd(`ADDR_RESULT_LOW, exp_lo(d, 1'b0)); // kept while off
        wr(`ADDR_CTRL_PRIMARY, 8'h80);
        wr(`ADDR_CTRL_PRIMARY, 8'h00);
        rd(`ADDR_CTRL_PRIMARY, 32'h0); // no start while off
        rd(`ADDR_IRQ_STATUS, 32'h0);
        report_and_stop();
    end
endmodule
